// >>> hw/cfg_loader.v
// Configuration auto-loader: reads a serial EEPROM after reset, copies the
// image into on-chip storage, decodes configuration and drives wake pins.
// Assumes a Microwire-style EEPROM with byte organisation and that all inputs
// are synchronous to clk.
// Notes on behaviour
// - Wake polarity bit picks low (0) or high (1) active wake level.
// - Buffer bit: 1 push-pull; 0 open drain if low, open source if high.
// - Wake source bit: 0 magic packet, 1 PHY link-up.
// - Link-up wake is blocked while the external PHY is selected.
// - Detection bit: level wake input active low (0) or active high (1).
// - Level wake input wakes in both internal and external PHY modes.
// - All wake bits are ignored while the wake enable bit is clear.
// - Byte at EEPROM address zero is the signature, valid value A5h.
// - Any other signature means no EEPROM; built-in defaults are used.
// - Defaults: all-ones station address, 1 ms full-speed, 4 ms hi-speed polling.
// - Default flags 04h, max power FAh; remote-wakeup strap modifies flags.
// - Load starts on USB reset, power-on reset, reset pin or soft reset.
// - Loader reads byte zero first; EEPROM present only if it reads A5h.
// - USB-reset load refreshes only the station address.
// - Valid image is copied entirely into the 512-byte storage.
// - USB control block reads the storage on demand.
// - Bad signature ends initialisation at once with default register values.
// - USB PHY held disconnected after reset until the load finishes.
// - Wake enable routes events to internal or external PHY wake pin.
// - Pulse mode: 1.5 ms pulse when length bit clear, 150 ms when set.
//
// Added by the designer: the placing of the registers and register access over Avalon-MM.
`timescale 1ns/1ps
`default_nettype none
`include "cfg_loader_defines.vh"

module cfg_loader #(
    parameter AW = 9,
    parameter EE_BYTES = 512,
    parameter SRAM_BYTES = 512,
    parameter [15:0] EE_DIV = `EE_CLK_DIV,
    parameter [31:0] WAKE_SHORT_CYC = `WAKE_SHORT_US * `CLK_MHZ,
    parameter [31:0] WAKE_LONG_CYC = `WAKE_LONG_US * `CLK_MHZ
) (
    input wire clk,
    input wire rst,
    input wire external_reset_pin_n,
    input wire usb_bus_reset,
    input wire remote_wakeup_strap,
    input wire phy_source_select_pin,
    input wire magic_packet_event,
    input wire link_up_event,
    input wire level_wake_input,
    input wire [4:0] avs_address,
    input wire avs_read,
    input wire avs_write,
    input wire [31:0] avs_writedata,
    input wire [3:0] avs_byteenable,
    output reg [31:0] avs_readdata,
    output reg avs_waitrequest,
    input wire usb_ctl_rd_req,
    input wire [AW-1:0] usb_ctl_rd_addr,
    output reg [7:0] usb_ctl_rd_data,
    output reg usb_ctl_rd_valid,
    output reg eeprom_cs,
    output reg eeprom_sk,
    output reg eeprom_di,
    input wire eeprom_do,
    output reg usb_phy_disconnect,
    output reg load_done,
    output reg internal_phy_wake_pin_o,
    output reg internal_phy_wake_pin_oe,
    output reg external_phy_wake_pin_o,
    output reg external_phy_wake_pin_oe
);
    localparam CMD_BITS = 3 + AW;
    localparam [4:0] TOT_BITS = CMD_BITS + 9;
    localparam [1:0] L_IDLE = 2'h0;
    localparam [1:0] L_SHIFT = 2'h1;
    localparam [1:0] L_GAP = 2'h2;

    // Merge write data into a register under byte enables
    function [31:0] be_merge;
        input [31:0] old_v;
        input [31:0] new_v;
        input [3:0] be;
        integer i;
        begin
            for (i = 0; i < 4; i = i + 1) begin
                be_merge[i*8 +: 8] = be[i] ? new_v[i*8 +: 8] : old_v[i*8 +: 8];
            end
        end
    endfunction

    reg [7:0] sram_q [0:SRAM_BYTES-1];
    reg [1:0] state_q;
    reg mac_only_q;
    reg full_pend_q;
    reg usb_rst_q;
    reg [15:0] div_q;
    reg tick_q;
    reg [4:0] bit_cnt_q;
    reg [CMD_BITS-1:0] shreg_q;
    reg [7:0] rx_q;
    reg [AW-1:0] byte_addr_q;
    reg image_valid_q;
    reg soft_reset_q;
    reg [31:0] addr_low_q;
    reg [15:0] addr_high_q;
    reg [7:0] fs_poll_q;
    reg [7:0] hs_poll_q;
    reg [7:0] cfg_flags_q;
    reg [7:0] max_power_q;
    reg [7:0] wake_flags_q;
    reg wake_level_q;
    reg [31:0] pulse_cnt_q;
    reg wake_active_d;
    reg pin_o_d;
    reg pin_oe_d;
    reg [31:0] rd_mux;
    wire bus_done = ~avs_waitrequest & (avs_read | avs_write);
    wire wr_en = avs_write & ~avs_waitrequest;
    wire full_trigger = soft_reset_q | ~external_reset_pin_n;
    wire usb_rst_rise = usb_bus_reset & ~usb_rst_q;
    wire byte_end = (state_q == L_SHIFT) & tick_q & eeprom_sk & (bit_cnt_q == TOT_BITS);
    wire last_addr = mac_only_q ? (byte_addr_q == `IMG_MAC_LAST)
                                : (byte_addr_q == EE_BYTES - 1);

    // Serial clock divider; one-cycle tick per half period of the EEPROM clock
    always @(posedge clk) begin
        if (rst || div_q == EE_DIV - 16'h0001) begin
            div_q <= 16'h0000;
            tick_q <= ~rst;
        end else begin
            div_q <= div_q + 16'h0001;
            tick_q <= 1'b0;
        end
    end

    // Loader sequencer
    // Load triggers
    // Reset pin and soft reset abort any load in flight.
    always @(posedge clk) begin
        if (rst) begin
            state_q <= L_IDLE;
            full_pend_q <= 1'b1;
            mac_only_q <= 1'b0;
            usb_rst_q <= 1'b0;
            eeprom_cs <= 1'b0;
            eeprom_sk <= 1'b0;
            eeprom_di <= 1'b0;
            bit_cnt_q <= 5'h00;
            shreg_q <= {CMD_BITS{1'b0}};
            rx_q <= 8'h00;
            byte_addr_q <= {AW{1'b0}};
            load_done <= 1'b0;
        end else begin
            if (tick_q)
                usb_rst_q <= usb_bus_reset;
            if (full_trigger) begin
                state_q <= L_IDLE;
                full_pend_q <= 1'b1;
                load_done <= 1'b0;
                eeprom_cs <= 1'b0;
                eeprom_sk <= 1'b0;
            end else begin
                case (state_q)
                    L_IDLE: begin
                        if (tick_q && (full_pend_q || usb_rst_rise)) begin
                            mac_only_q <= ~full_pend_q;
                            full_pend_q <= 1'b0;
                            load_done <= 1'b0;
                            byte_addr_q <= `IMG_SIG_ADDR;
                            shreg_q <= {`EE_READ_OP, `IMG_SIG_ADDR};
                            eeprom_di <= 1'b1;
                            eeprom_cs <= 1'b1;
                            bit_cnt_q <= 5'h00;
                            state_q <= L_SHIFT;
                        end
                    end
                    L_SHIFT: begin
                        if (tick_q) begin
                            if (!eeprom_sk) begin
                                // Rising edge: sample data bits after the dummy zero
                                eeprom_sk <= 1'b1;
                                bit_cnt_q <= bit_cnt_q + 5'h01;
                                if (bit_cnt_q > CMD_BITS)
                                    rx_q <= {rx_q[6:0], eeprom_do};
                            end else begin
                                eeprom_sk <= 1'b0;
                                shreg_q <= {shreg_q[CMD_BITS-2:0], 1'b0};
                                eeprom_di <= shreg_q[CMD_BITS-2];
                                if (bit_cnt_q == TOT_BITS) begin
                                    eeprom_cs <= 1'b0;
                                    eeprom_di <= 1'b0;
                                    if ((byte_addr_q == `IMG_SIG_ADDR && rx_q != `IMG_SIGNATURE) || last_addr) begin
                                        state_q <= L_IDLE;
                                        load_done <= 1'b1;
                                    end else begin
                                        byte_addr_q <= byte_addr_q + 1'b1;
                                        state_q <= L_GAP;
                                    end
                                end
                            end
                        end
                    end
                    L_GAP: begin
                        // Chip select stays low one half period between reads
                        if (tick_q) begin
                            shreg_q <= {`EE_READ_OP, byte_addr_q};
                            eeprom_di <= 1'b1;
                            eeprom_cs <= 1'b1;
                            bit_cnt_q <= 5'h00;
                            state_q <= L_SHIFT;
                        end
                    end
                    default: state_q <= L_IDLE;
                endcase
            end
        end
    end

    // Image copy into storage
    // Only a full load writes: the signature byte always, the rest only after a good signature; a USB-reset load never does.
    always @(posedge clk) begin
        if (byte_end && !mac_only_q && (image_valid_q || byte_addr_q == `IMG_SIG_ADDR))
            sram_q[byte_addr_q] <= rx_q;
    end

    // Read port for the USB control block, one cycle latency
    always @(posedge clk) begin
        if (rst) begin
            usb_ctl_rd_data <= 8'h00;
            usb_ctl_rd_valid <= 1'b0;
        end else begin
            usb_ctl_rd_valid <= usb_ctl_rd_req;
            if (usb_ctl_rd_req)
                usb_ctl_rd_data <= sram_q[usb_ctl_rd_addr];
        end
    end

    always @(posedge clk) begin
        if (rst)
            usb_phy_disconnect <= 1'b1;
        else if (full_trigger || (state_q != L_IDLE && !mac_only_q) || full_pend_q)
            usb_phy_disconnect <= ~(byte_end && last_addr && !mac_only_q) &
                                  ~(byte_end && byte_addr_q == `IMG_SIG_ADDR && rx_q != `IMG_SIGNATURE);
        else
            usb_phy_disconnect <= 1'b0;
    end

    // Configuration registers: defaults at full-load start, overwritten by a good image
    always @(posedge clk) begin
        if (rst || full_trigger || (state_q == L_IDLE && tick_q && full_pend_q)) begin
            addr_low_q <= `DEF_ADDR_LOW;
            addr_high_q <= `DEF_ADDR_HIGH;
            fs_poll_q <= `DEF_FS_POLL;
            hs_poll_q <= `DEF_HS_POLL;
            cfg_flags_q <= (`DEF_CFG_FLAGS & ~(8'h01 << `CFG_RWAKE_BIT)) |
                           ({7'h00, remote_wakeup_strap} << `CFG_RWAKE_BIT);
            max_power_q <= `DEF_MAX_POWER;
            wake_flags_q <= `DEF_WAKE_FLAGS;
            image_valid_q <= 1'b0;
        end else if (byte_end) begin
            if (byte_addr_q == `IMG_SIG_ADDR)
                image_valid_q <= (rx_q == `IMG_SIGNATURE);
            else if (image_valid_q) begin
                case (byte_addr_q)
                    9'h001: addr_low_q[7:0] <= rx_q;
                    9'h002: addr_low_q[15:8] <= rx_q;
                    9'h003: addr_low_q[23:16] <= rx_q;
                    9'h004: addr_low_q[31:24] <= rx_q;
                    9'h005: addr_high_q[7:0] <= rx_q;
                    9'h006: addr_high_q[15:8] <= rx_q;
                    `IMG_FS_POLL: if (!mac_only_q) fs_poll_q <= rx_q;
                    `IMG_HS_POLL: if (!mac_only_q) hs_poll_q <= rx_q;
                    `IMG_CFG_FLAGS: if (!mac_only_q) cfg_flags_q <= rx_q;
                    `IMG_MAX_POWER: if (!mac_only_q) max_power_q <= rx_q;
                    `IMG_WAKE_FLAGS: if (!mac_only_q) wake_flags_q <= rx_q;
                    default: ;
                endcase
            end
        end else if (wr_en && avs_address == `REG_ADDR_LOW) begin
            addr_low_q <= be_merge(addr_low_q, avs_writedata, avs_byteenable);
        end else if (wr_en && avs_address == `REG_ADDR_HIGH) begin
            addr_high_q <= {avs_byteenable[1] ? avs_writedata[15:8] : addr_high_q[15:8],
                            avs_byteenable[0] ? avs_writedata[7:0] : addr_high_q[7:0]};
        end
    end

    // Wake event qualification
    wire wf_en = wake_flags_q[`WF_ENABLE];
    wire wf_pol = wake_flags_q[`WF_POL];
    // No link-up wake on external PHY
    wire src_event = wake_flags_q[`WF_LINKUP] ? (link_up_event & ~phy_source_select_pin)
                                               : magic_packet_event;
    wire lvl_event = wake_flags_q[`WF_DET_HIGH] ? level_wake_input : ~level_wake_input;
    wire wake_event = wf_en & (src_event | lvl_event);
    wire wake_clr = wr_en && avs_address == `REG_WAKE_STATUS && avs_writedata[0];

    // Level mode holds until software clears; a new event wins over the clear
    always @(posedge clk) begin
        if (rst || !wf_en)
            wake_level_q <= 1'b0;
        else if (wake_event && !wake_flags_q[`WF_PULSE])
            wake_level_q <= 1'b1;
        else if (wake_clr)
            wake_level_q <= 1'b0;
    end

    // Pulse length timer
    // Events during a running pulse are absorbed, not queued.
    always @(posedge clk) begin
        if (rst || !wf_en)
            pulse_cnt_q <= 32'h00000000;
        else if (pulse_cnt_q != 32'h00000000)
            pulse_cnt_q <= pulse_cnt_q - 32'h00000001;
        else if (wake_event && wake_flags_q[`WF_PULSE])
            pulse_cnt_q <= wake_flags_q[`WF_LONG] ? WAKE_LONG_CYC : WAKE_SHORT_CYC;
    end

    always @* begin
        wake_active_d = wake_level_q | (pulse_cnt_q != 32'h00000000);
        if (!wf_en) begin
            pin_o_d = 1'b0;
            pin_oe_d = 1'b0;
        end else if (wake_flags_q[`WF_PUSHPULL]) begin
            pin_o_d = wake_active_d ? wf_pol : ~wf_pol;
            pin_oe_d = 1'b1;
        end else begin
            pin_o_d = wf_pol;
            pin_oe_d = wake_active_d;
        end
    end

    always @(posedge clk) begin
        if (rst) begin
            internal_phy_wake_pin_o <= 1'b0;
            internal_phy_wake_pin_oe <= 1'b0;
            external_phy_wake_pin_o <= 1'b0;
            external_phy_wake_pin_oe <= 1'b0;
        end else begin
            internal_phy_wake_pin_o <= pin_o_d & ~phy_source_select_pin;
            internal_phy_wake_pin_oe <= pin_oe_d & ~phy_source_select_pin;
            external_phy_wake_pin_o <= pin_o_d & phy_source_select_pin;
            external_phy_wake_pin_oe <= pin_oe_d & phy_source_select_pin;
        end
    end

    // Soft reset command bit self-clears after one cycle
    always @(posedge clk) begin
        if (rst)
            soft_reset_q <= 1'b0;
        else
            soft_reset_q <= wr_en && avs_address == `REG_CONTROL &&
                            avs_byteenable[0] && avs_writedata[`CTL_SOFT_RESET];
    end

    // Read multiplexer; unmapped offsets read zero
    always @* begin
        case (avs_address)
            `REG_STATUS: rd_mux = {29'h00000000, state_q != L_IDLE || full_pend_q, load_done, image_valid_q};
            `REG_ADDR_LOW: rd_mux = addr_low_q;
            `REG_ADDR_HIGH: rd_mux = {16'h0000, addr_high_q};
            `REG_POLL: rd_mux = {16'h0000, hs_poll_q, fs_poll_q};
            `REG_CFG: rd_mux = {16'h0000, max_power_q, cfg_flags_q};
            `REG_WAKE_FLAGS: rd_mux = {24'h000000, wake_flags_q};
            `REG_WAKE_STATUS: rd_mux = {31'h00000000, wake_active_d};
            default: rd_mux = 32'h00000000;
        endcase
    end

    // Avalon slave: one wait cycle, then the transfer completes
    always @(posedge clk) begin
        if (rst) begin
            avs_waitrequest <= 1'b1;
            avs_readdata <= 32'h00000000;
        end else if (bus_done) begin
            avs_waitrequest <= 1'b1;
        end else if (avs_read || avs_write) begin
            avs_waitrequest <= 1'b0;
            avs_readdata <= avs_read ? rd_mux : 32'h00000000;
        end
    end

endmodule // cfg_loader
`default_nettype wire

// >>> inc/cfg_loader_defines.vh
// Constants for the configuration auto-loader: register map, image layout,
// reset values and wake timing. Definitions only.
`ifndef CFG_LOADER_DEFINES_VH
`define CFG_LOADER_DEFINES_VH

// Register byte offsets on the Avalon-MM slave
`define REG_STATUS 5'h00
`define REG_CONTROL 5'h04
`define REG_ADDR_LOW 5'h08
`define REG_ADDR_HIGH 5'h0C
`define REG_POLL 5'h10
`define REG_CFG 5'h14
`define REG_WAKE_FLAGS 5'h18
`define REG_WAKE_STATUS 5'h1C

// Image layout in the EEPROM
`define IMG_SIGNATURE 8'hA5
`define IMG_SIG_ADDR 9'h000
`define IMG_MAC_FIRST 9'h001
`define IMG_MAC_LAST 9'h006
`define IMG_FS_POLL 9'h007
`define IMG_HS_POLL 9'h008
`define IMG_CFG_FLAGS 9'h009
`define IMG_MAX_POWER 9'h00A
`define IMG_WAKE_FLAGS 9'h00B

// Defaults used when no valid image is found
`define DEF_ADDR_LOW 32'hFFFFFFFF
`define DEF_ADDR_HIGH 16'hFFFF
`define DEF_FS_POLL 8'h01
`define DEF_HS_POLL 8'h04
`define DEF_CFG_FLAGS 8'h04
`define DEF_MAX_POWER 8'hFA
`define DEF_WAKE_FLAGS 8'h00

// Field positions
`define CFG_RWAKE_BIT 2
`define WF_ENABLE 7
`define WF_PULSE 6
`define WF_LONG 5
`define WF_POL 4
`define WF_PUSHPULL 3
`define WF_LINKUP 2
`define WF_DET_HIGH 1
`define CTL_SOFT_RESET 0

// Serial EEPROM read opcode: start bit then read op
`define EE_READ_OP 3'h6

// Timing
`define CLK_MHZ 50
`define WAKE_SHORT_US 1500
`define WAKE_LONG_US 150000
`define EE_CLK_DIV 16'h0019

`endif

// >>> verif/cfg_loader_monitor.sv
// Checker on the loader ports: bus handshake, PHY hold, load length, wake pin choice.
// Assumes one clock domain with synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none
module cfg_loader_monitor #(
    parameter int EE_BYTES = 512,
    parameter [15:0] EE_DIV = 16'h0019
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic external_reset_pin_n,
    input wire logic phy_source_select_pin,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic avs_waitrequest,
    input wire logic usb_ctl_rd_req,
    input wire logic usb_ctl_rd_valid,
    input wire logic eeprom_cs,
    input wire logic usb_phy_disconnect,
    input wire logic load_done,
    input wire logic internal_phy_wake_pin_oe,
    input wire logic external_phy_wake_pin_oe
);
    localparam int LIMIT = EE_BYTES * EE_DIV * 64 + 64;
    logic [31:0] busy_q;
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    // Cycles in a load
    always @(posedge clk) begin
        if (rst || load_done || !external_reset_pin_n) busy_q <= 32'h0;
        else busy_q <= busy_q + 32'h1;
    end
    sequence s_req; (avs_read || avs_write) && avs_waitrequest; endsequence
    sequence s_ack; !avs_waitrequest; endsequence
    sequence s_int; !phy_source_select_pin [*3]; endsequence
    sequence s_ext; phy_source_select_pin [*3]; endsequence
    property p_rst;
        disable iff (1'b0) rst |=> avs_waitrequest && usb_phy_disconnect && !load_done && !eeprom_cs
            && !internal_phy_wake_pin_oe && !external_phy_wake_pin_oe;
    endproperty
    a_rst: assert property (p_rst) else $error("reset values wrong");
    property p_ack; s_req |=> s_ack; endproperty
    a_ack: assert property (p_ack) else $error("bus answer late");
    property p_rdv; 1'b1 |=> usb_ctl_rd_valid == $past(usb_ctl_rd_req); endproperty
    a_rdv: assert property (p_rdv) else $error("storage valid wrong");
    property p_hold; usb_phy_disconnect && !load_done |=> usb_phy_disconnect || load_done; endproperty
    a_hold: assert property (p_hold) else $error("PHY released early");
    property p_rel; $fell(usb_phy_disconnect) |-> load_done; endproperty
    a_rel: assert property (p_rel) else $error("PHY released without done");
    property p_pin; $fell(external_reset_pin_n) |-> ##[1:2] (usb_phy_disconnect && !load_done); endproperty
    a_pin: assert property (p_pin) else $error("reset pin ignored");
    property p_int_off; s_ext |-> !internal_phy_wake_pin_oe; endproperty
    a_int_off: assert property (p_int_off) else $error("internal wake pin driven");
    property p_ext_off; s_int |-> !external_phy_wake_pin_oe; endproperty
    a_ext_off: assert property (p_ext_off) else $error("external wake pin driven");
    property p_load_time; busy_q < LIMIT; endproperty
    a_load_time: assert property (p_load_time) else $error("load too long");
endmodule // cfg_loader_monitor
bind cfg_loader cfg_loader_monitor #(.EE_BYTES(EE_BYTES), .EE_DIV(EE_DIV)) mon (.*);
`default_nettype wire

// >>> verif/ee_model.sv
// Serial EEPROM model: byte organised, answers every command as a read.
// Assumes cs, sk, di from the loader; do has no pull and toggles when released.
`timescale 1ns/1ps
`default_nettype none
module ee_model (
    input wire logic cs,
    input wire logic sk,
    input wire logic di,
    output var logic dout
);
    logic [7:0] mem [0:511];
    logic [8:0] addr;
    int n;
    initial dout = 1'b0;
    // Count clocks; bits 4..12 of the command are the address
    always @(posedge sk or negedge cs) begin
        if (!cs) begin
            n <= 0;
        end else begin
            n <= n + 1;
            if (n >= 3 && n < 12) addr <= {addr[7:0], di};
        end
    end
    // Data after the dummy clock; outside it the line never holds a stale bit
    always @(negedge sk or negedge cs) begin
        if (cs && n >= 13 && n <= 20) dout <= mem[addr][20-n];
        else dout <= ~dout;
    end
endmodule // ee_model
`default_nettype wire

// >>> verif/test_eeprom_config_autoload.sv
// Self-checking bench for the configuration loader with an EEPROM model.
// Assumes short divider, 16-byte image and shortened wake pulses.
`timescale 1ns/1ps
`default_nettype none
`include "cfg_loader_defines.vh"
`define chk(got, exp) begin samples_checked++; if ((got) !== (exp)) begin bad_count++; \
$display("BAD t=%0t got=%0h exp=%0h", $time, (got), (exp)); end end
module test_eeprom_config_autoload;
    localparam int SHORT = 20;
    localparam int LONG = 200;
    logic clk = 1'b0, rst = 1'b1, external_reset_pin_n = 1'b1, usb_bus_reset = 1'b0;
    logic remote_wakeup_strap = 1'b1, phy_source_select_pin = 1'b0, magic_packet_event = 1'b0;
    logic link_up_event = 1'b0, level_wake_input = 1'b1, avs_read = 1'b0, avs_write = 1'b0;
    logic [4:0] avs_address = 5'h00;
    logic [31:0] avs_writedata = 32'h0, avs_readdata, q;
    logic [3:0] avs_byteenable = 4'hF;
    logic [8:0] usb_ctl_rd_addr = 9'h000;
    logic usb_ctl_rd_req = 1'b0, avs_waitrequest, usb_ctl_rd_valid, eeprom_cs, eeprom_sk, eeprom_di;
    logic [7:0] usb_ctl_rd_data;
    logic eeprom_do, usb_phy_disconnect, load_done, internal_phy_wake_pin_o, internal_phy_wake_pin_oe;
    logic external_phy_wake_pin_o, external_phy_wake_pin_oe;
    int bad_count = 0, samples_checked = 0, cyc = 0;
    cfg_loader #(.EE_DIV(16'h0002), .EE_BYTES(16), .WAKE_SHORT_CYC(SHORT), .WAKE_LONG_CYC(LONG)) uut (.*);
    ee_model ee (.cs(eeprom_cs), .sk(eeprom_sk), .di(eeprom_di), .dout(eeprom_do));
    always #10 clk = ~clk;
    // Watchdog well above the ~20k cycles needed
    always @(posedge clk) begin
        cyc++;
        if (cyc == 60000) begin
            bad_count++;
            wrap_up;
        end
    end
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    // One Avalon transfer; held until waitrequest is seen low
    task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
        @(posedge clk);
        avs_read <= !w;
        avs_write <= w;
        avs_address <= a;
        avs_writedata <= d;
        do @(posedge clk); while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask
    task automatic rd(input logic [4:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        `chk(q, e)
    endtask
    task automatic wr(input logic [4:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask
    task automatic srd(input logic [8:0] a, input logic [7:0] e);
        @(posedge clk);
        usb_ctl_rd_req <= 1'b1;
        usb_ctl_rd_addr <= a;
        @(posedge clk);
        usb_ctl_rd_req <= 1'b0;
        @(negedge clk);
        `chk({usb_ctl_rd_valid, usb_ctl_rd_data}, {1'b1, e})
    endtask
    task automatic wait_load;
        while (load_done !== 1'b0) @(posedge clk);
        while (load_done !== 1'b1) @(posedge clk);
    endtask
    // Full reload by soft reset or reset pin
    task automatic load(input logic [7:0] f, input logic pin);
        ee.mem[11] = f;
        @(posedge clk);
        if (pin) begin
            external_reset_pin_n <= 1'b0;
            repeat (3) @(posedge clk);
            external_reset_pin_n <= 1'b1;
        end else begin
            wr(`REG_CONTROL, 32'h1);
        end
        wait_load;
    endtask
    task automatic rd_addr;
        rd(`REG_ADDR_LOW, {ee.mem[4], ee.mem[3], ee.mem[2], ee.mem[1]});
        rd(`REG_ADDR_HIGH, {16'h0, ee.mem[6], ee.mem[5]});
    endtask
    task automatic t_defaults;
        rd(`REG_STATUS, 32'h2);
        rd(`REG_ADDR_LOW, 32'hFFFFFFFF);
        rd(`REG_ADDR_HIGH, 32'h0000FFFF);
        rd(`REG_POLL, 32'h0401);
        rd(`REG_CFG, 32'hFA04);
        srd(9'h000, 8'h5A);
        wr(`REG_POLL, 32'h0);
        wr(5'h1D, 32'h5);
        rd(`REG_POLL, 32'h0401);
        rd(5'h1D, 32'h0);
        wr(`REG_ADDR_LOW, 32'h12345678);
        rd(`REG_ADDR_LOW, 32'h12345678);
        remote_wakeup_strap <= 1'b0;
        load(8'h00, 1'b0);
        rd(`REG_CFG, 32'hFA00);
        rd(`REG_ADDR_LOW, 32'hFFFFFFFF);
        $display("defaults done");
    endtask
    task automatic t_image;
        ee.mem[0] = 8'hA5;
        load(8'h00, 1'b0);
        rd(`REG_STATUS, 32'h3);
        rd_addr;
        rd(`REG_POLL, 32'h0802);
        rd(`REG_CFG, 32'h6405);
        for (int i = 0; i < 16; i++) srd(i[8:0], ee.mem[i]);
        $display("image done");
    endtask
    task automatic t_usb;
        for (int i = 1; i < 9; i++) ee.mem[i] = ee.mem[i] + 8'h11;
        @(posedge clk);
        usb_bus_reset <= 1'b1;
        repeat (2) @(posedge clk);
        usb_bus_reset <= 1'b0;
        wait_load;
        rd_addr;
        rd(`REG_POLL, 32'h0802);
        `chk(usb_phy_disconnect, 1'b0)
        $display("usb reset done");
    endtask
    // Open drain or source drives only while active; push-pull drives whenever wake is enabled
    task automatic chk_pin(input logic [7:0] f, input logic ph, input logic act);
        logic [1:0] e;
        e = !f[7] ? 2'b00 : f[3] ? {act ~^ f[4], 1'b1} : {f[4], act};
        if (ph) `chk({external_phy_wake_pin_oe, internal_phy_wake_pin_oe}, {e[0], 1'b0})
        else `chk({internal_phy_wake_pin_oe, external_phy_wake_pin_oe}, {e[0], 1'b0})
        if (e[0]) `chk(ph ? external_phy_wake_pin_o : internal_phy_wake_pin_o, e[1])
    endtask
    task automatic t_wake;
        logic [11:0] tab [8] = '{12'h981, 12'h809, 12'h843, 12'h84A, 12'h802, 12'h92D, 12'h885, 12'h1C0};
        logic [7:0] f;
        logic [1:0] ev;
        logic ph, act;
        for (int k = 0; k < 8; k++) begin
            {f, ph, ev, act} = tab[k];
            phy_source_select_pin <= ph;
            load(f, k == 0);
            level_wake_input <= !f[1];
            wr(`REG_WAKE_STATUS, 32'h1);
            repeat (2) @(posedge clk);
            chk_pin(f, ph, 1'b0);
            case (ev)
                2'd0: magic_packet_event <= 1'b1;
                2'd1: link_up_event <= 1'b1;
                default: level_wake_input <= f[1];
            endcase
            repeat (2) @(posedge clk);
            magic_packet_event <= 1'b0;
            link_up_event <= 1'b0;
            level_wake_input <= !f[1];
            repeat (3) @(posedge clk);
            chk_pin(f, ph, act);
            rd(`REG_WAKE_STATUS, {31'h0, act});
            wr(`REG_WAKE_STATUS, 32'h1);
            repeat (3) @(posedge clk);
            chk_pin(f, ph, 1'b0);
        end
        $display("wake done");
    endtask
    task automatic t_pulse;
        int n;
        for (int k = 0; k < 2; k++) begin
            load(k ? 8'hE0 : 8'hC0, 1'b0);
            magic_packet_event <= 1'b1;
            @(posedge clk);
            magic_packet_event <= 1'b0;
            n = 0;
            repeat (LONG + 50) begin
                @(posedge clk);
                n += internal_phy_wake_pin_oe;
            end
            `chk(n, k ? LONG : SHORT)
        end
        $display("pulse done");
    endtask
    initial begin
        for (int i = 0; i < 512; i++) ee.mem[i] = 8'(i * 37 + 11);
        ee.mem[0] = 8'h5A;
        ee.mem[7] = 8'h02;
        ee.mem[8] = 8'h08;
        ee.mem[9] = 8'h05;
        ee.mem[10] = 8'h64;
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        wait_load;
        t_defaults;
        t_image;
        t_usb;
        t_wake;
        t_pulse;
        wrap_up;
    end
endmodule // test_eeprom_config_autoload
`default_nettype wire
